// ==== verilog/rarms_defines.svh ====
// Register offsets, field positions, reset values and sample counts
// for the result and RMS register slice. Assumes 8-bit register space.
// Behaviour
// [RL1] Channels 5-7 each have a read-only low result byte, reset zero.
// [RL2] Channels 5-7 each have a read-only high result byte, reset zero.
// [RL3] Setup bits 7:4 select the RMS input channel, read-write, reset zero.
// [RL4] Setup bit 2 set removes the DC component from RMS; reset zero.
// [RL5] Setup bits 1:0 pick window 1024, 4096, 16384 or 65536 samples.
// [RL6] Forty further samples beyond the window finish the RMS computation.
// [RL7] Setup bit 3 is reserved, reads zero, ignores writes.
// [RL8] A read-only register holds the RMS result low byte, reset zero.
// [RL9] The next address holds the RMS result high byte, reset zero.
// [RL10] High byte is result bits 11:4; low byte upper nibble bits 3:0.
`ifndef RARMS_DEFINES_SVH
`define RARMS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RARMS_OFS_CH5_LOW 8'haa
`define RARMS_OFS_CH5_HIGH 8'hab
`define RARMS_OFS_CH6_LOW 8'hac
`define RARMS_OFS_CH6_HIGH 8'had
`define RARMS_OFS_CH7_LOW 8'hae
`define RARMS_OFS_CH7_HIGH 8'haf
`define RARMS_OFS_SETUP 8'hc0
`define RARMS_OFS_RMS_LOW 8'hc1
`define RARMS_OFS_RMS_HIGH 8'hc2

// ----------------------------------------------------------------------
// Setup register fields and reset values
// ----------------------------------------------------------------------
`define RARMS_SEL_MSB 7
`define RARMS_SEL_LSB 4
`define RARMS_RSVD_BIT 3
`define RARMS_DC_BIT 2
`define RARMS_WIN_MSB 1
`define RARMS_WIN_LSB 0
`define RARMS_SETUP_WMASK 8'hf7
`define RARMS_SETUP_RESET 8'h00
`define RARMS_RESULT_RESET 8'h00

// ----------------------------------------------------------------------
// Sample counts
// ----------------------------------------------------------------------
`define RARMS_WIN_1K 17'h00400
`define RARMS_WIN_4K 17'h01000
`define RARMS_WIN_16K 17'h04000
`define RARMS_WIN_64K 17'h10000
`define RARMS_EXTRA_SAMPLES 17'h00028

`endif

// ==== verilog/rarms_pkg.sv ====
// Types shared by the result and RMS register slice.
// Assumes the defines header is compiled alongside.
package rarms_pkg;

   // Register access from the device's serial interface engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rarms_req_t;

   // One finished conversion from the converter core
   typedef struct packed {
      logic valid;
      logic [2:0] ch;
      logic [11:0] data;
   } rarms_conv_t;

   // Configuration handed to the RMS arithmetic
   typedef struct packed {
      logic [3:0] input_select;
      logic remove_offset;
      logic [1:0] window_length;
   } rarms_cfg_t;

   typedef enum logic [1:0] {
      RARMS_WIN_CODE_1K,
      RARMS_WIN_CODE_4K,
      RARMS_WIN_CODE_16K,
      RARMS_WIN_CODE_64K
   } rarms_win_t;

endpackage

// ==== verilog/rarms_regs.sv ====
// Result and RMS register slice: latest results of channels 5 to 7,
// RMS setup and RMS result. Assumes the serial interface engine issues
// single-cycle register requests on ref_clk and the converter core and
// RMS arithmetic run on the same clock.
`timescale 1ns/1ps
`include "rarms_defines.svh"

module rarms_regs #(
   parameter int FIRST_CH = 5,
   parameter int NUM_CH = 3
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire rarms_pkg::rarms_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire rarms_pkg::rarms_conv_t conv,
   input wire logic [15:0] rms_engine_value,
   output rarms_pkg::rarms_cfg_t rms_setup,
   output logic rms_restart,
   output logic rms_done
);

   // -------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------
   // The read map and the offsets are fixed to channels 5 to 7
   if (FIRST_CH != 5)
   begin : g_bad_first_ch
      $error("Only channel 5 may lead this slice");
   end
   if (NUM_CH != 3)
   begin : g_bad_num_ch
      $error("Exactly three channels are mapped in this slice");
   end
   // A writable reserved bit would break its read-as-zero behaviour
   if ((`RARMS_SETUP_WMASK & (8'h01 << `RARMS_RSVD_BIT)) != 8'h00)
   begin : g_bad_mask
      $error("Reserved setup bit must stay masked");
   end
   // The sample counter must hold the longest window plus its tail
   if (32'(`RARMS_WIN_64K) + 32'(`RARMS_EXTRA_SAMPLES) > 32'h0001ffff)
   begin : g_bad_count
      $error("Window plus tail does not fit the sample counter");
   end

   // -------------------------------------------------------------------
   // Latest conversion results
   // -------------------------------------------------------------------
   logic [7:0] ch_low_q [NUM_CH];
   logic [7:0] ch_high_q [NUM_CH];
   logic [NUM_CH-1:0] conv_hit;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_ch
         // Channels 0 to 4 are stored by the neighbouring slice
         assign conv_hit[gi] = conv.valid && conv.ch == 3'(FIRST_CH + gi);

         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
            begin
               ch_low_q[gi] <= `RARMS_RESULT_RESET; // RL1
               ch_high_q[gi] <= `RARMS_RESULT_RESET; // RL2
            end
            else if (conv_hit[gi])
            begin
               ch_high_q[gi] <= conv.data[11:4]; // RL10
               ch_low_q[gi] <= {conv.data[3:0], 4'h0}; // RL10
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // RMS setup register
   // -------------------------------------------------------------------
   logic [7:0] setup_q;
   logic setup_wr;

   assign setup_wr = reg_req.wr && reg_req.addr == `RARMS_OFS_SETUP;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         setup_q <= `RARMS_SETUP_RESET; // RL3
      end
      else if (setup_wr)
      begin
         // Reserved bit masked so it can never be set
         setup_q <= reg_req.wdata & `RARMS_SETUP_WMASK; // RL7
      end
   end

   assign rms_setup.input_select = setup_q[`RARMS_SEL_MSB:`RARMS_SEL_LSB]; // RL3
   assign rms_setup.remove_offset = setup_q[`RARMS_DC_BIT]; // RL4
   assign rms_setup.window_length =
      setup_q[`RARMS_WIN_MSB:`RARMS_WIN_LSB]; // RL5

   // Restart the arithmetic whenever its configuration may have changed
   assign rms_restart = setup_wr;

   // -------------------------------------------------------------------
   // RMS sample counting
   // -------------------------------------------------------------------
   logic [16:0] win_len;
   logic [16:0] target;
   logic [16:0] count_q;
   logic sample_hit;
   logic last_sample;

   always_comb
   begin
      unique case (rarms_pkg::rarms_win_t'(rms_setup.window_length))
         rarms_pkg::RARMS_WIN_CODE_1K: win_len = `RARMS_WIN_1K; // RL5
         rarms_pkg::RARMS_WIN_CODE_4K: win_len = `RARMS_WIN_4K; // RL5
         rarms_pkg::RARMS_WIN_CODE_16K: win_len = `RARMS_WIN_16K; // RL5
         rarms_pkg::RARMS_WIN_CODE_64K: win_len = `RARMS_WIN_64K; // RL5
      endcase
   end

   // 65536 + 40 fits in 17 bits, so the sum cannot wrap
   assign target = win_len + `RARMS_EXTRA_SAMPLES; // RL6
   assign sample_hit = conv.valid
      && {1'b0, conv.ch} == rms_setup.input_select;
   // Final sample of the window plus its tail
   assign last_sample = count_q == target - 17'h00001; // RL6

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= 17'h00000;
      end
      else if (setup_wr)
      begin
         count_q <= 17'h00000;
      end
      else if (sample_hit)
      begin
         if (last_sample)
         begin
            count_q <= 17'h00000; // RL6
         end
         else
         begin
            count_q <= count_q + 17'h00001;
         end
      end
   end

   assign rms_done = !setup_wr && sample_hit && last_sample; // RL6

   // -------------------------------------------------------------------
   // RMS result
   // -------------------------------------------------------------------
   logic [15:0] rms_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rms_q <= {`RARMS_RESULT_RESET, `RARMS_RESULT_RESET}; // RL8 RL9
      end
      else if (rms_done)
      begin
         // Result only changes once the whole window plus tail is in
         rms_q <= rms_engine_value; // RL6
      end
   end

   // -------------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------------
   logic [7:0] rdata_d;

   always_comb
   begin
      unique case (reg_req.addr)
         `RARMS_OFS_CH5_LOW: rdata_d = ch_low_q[0]; // RL1
         `RARMS_OFS_CH5_HIGH: rdata_d = ch_high_q[0]; // RL2
         `RARMS_OFS_CH6_LOW: rdata_d = ch_low_q[1]; // RL1
         `RARMS_OFS_CH6_HIGH: rdata_d = ch_high_q[1]; // RL2
         `RARMS_OFS_CH7_LOW: rdata_d = ch_low_q[2]; // RL1
         `RARMS_OFS_CH7_HIGH: rdata_d = ch_high_q[2]; // RL2
         `RARMS_OFS_SETUP: rdata_d = setup_q; // RL7
         `RARMS_OFS_RMS_LOW: rdata_d = rms_q[7:0]; // RL8
         `RARMS_OFS_RMS_HIGH: rdata_d = rms_q[15:8]; // RL9
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_req.rd)
      begin
         reg_rdata <= rdata_d;
      end
   end

endmodule

// ==== test/rarms_host.sv ====
// Host model: single-cycle register requests.
// Assumes one caller at a time.
`timescale 1ns/1ps
module rarms_host (
   input wire logic ref_clk,
   output rarms_pkg::rarms_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;
   task automatic xfer(logic w, logic [7:0] a, d, output logic [7:0] q);
      @(negedge ref_clk);
      reg_req = {w, !w, a, d};
      @(negedge ref_clk);
      reg_req = '0;
      q = reg_rdata;
   endtask
endmodule

// ==== test/rarms_regs_assertions.sv ====
// Port checker for rarms_regs.
// Assumes the bind at the foot.
`timescale 1ns/1ps
module rarms_regs_assertions (
   input wire logic ref_clk,
   input wire logic rst,
   input wire rarms_pkg::rarms_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire rarms_pkg::rarms_conv_t conv,
   input wire logic [15:0] rms_engine_value,
   input wire rarms_pkg::rarms_cfg_t rms_setup,
   input wire logic rms_restart,
   input wire logic rms_done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic wr0 = reg_req.wr && reg_req.addr == 8'hc0;
   wire logic rd = reg_req.rd;
   sequence s_cr(int c, logic [7:0] a);
      conv.valid && conv.ch == c ##1 rd && reg_req.addr == a;
   endsequence
   property p_rs; rms_restart == wr0; endproperty
   a_rs: assert property (p_rs) else $error("restart");
   property p_wr;
      wr0 |=> rms_setup == {$past(reg_req.wdata[7:4]), $past(reg_req.wdata[2:0])};
   endproperty
   a_wr: assert property (p_wr) else $error("setup");
   property p_kp; !wr0 |=> $stable(rms_setup); endproperty
   a_kp: assert property (p_kp) else $error("setup kept");
   property p_rc;
      rd && reg_req.addr == 8'hc0 |=>
         reg_rdata == {$past(rms_setup[6:3]), 1'b0, $past(rms_setup[2:0])};
   endproperty
   a_rc: assert property (p_rc) else $error("setup read");
   property p_hi; s_cr(5, 8'hab) |=> reg_rdata == $past(conv.data[11:4], 2);
   endproperty
   a_hi: assert property (p_hi) else $error("high");
   property p_lo;
      s_cr(7, 8'hae) |=> reg_rdata == {$past(conv.data[3:0], 2), 4'h0};
   endproperty
   a_lo: assert property (p_lo) else $error("low");
   property p_hd; !rd |=> $stable(reg_rdata); endproperty
   a_hd: assert property (p_hd) else $error("rdata");
   property p_rm;
      rms_done ##1 rd && reg_req.addr == 8'hc1 |=>
         reg_rdata == $past(rms_engine_value[7:0], 2);
   endproperty
   a_rm: assert property (p_rm) else $error("rms");
   property p_dn;
      rms_done |-> conv.valid && {1'b0, conv.ch} == rms_setup.input_select;
   endproperty
   a_dn: assert property (p_dn) else $error("done");
   // Samples seen since the last restart or finished result
   logic [16:0] seen_q;
   wire logic hit = conv.valid && {1'b0, conv.ch} == rms_setup.input_select;
   wire logic [16:0] lim =
      (17'h00400 << {rms_setup.window_length, 1'b0}) + 17'h00027;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         seen_q <= '0;
      else if (rms_restart || rms_done)
         seen_q <= '0;
      else if (hit)
         seen_q <= seen_q + 17'h00001;
   end
   property p_ct; hit && !rms_restart |-> rms_done == (seen_q == lim);
   endproperty
   a_ct: assert property (p_ct) else $error("window count");
endmodule
bind rarms_regs rarms_regs_assertions rarms_regs_assertions_inst (
   .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .conv(conv), .rms_engine_value(rms_engine_value), .rms_setup(rms_setup),
   .rms_restart(rms_restart), .rms_done(rms_done));

// ==== test/test_rarms_regs.sv ====
// Bench for rarms_regs against a register model.
// Assumes a 20 MHz ref_clk.
`timescale 1ns/1ps
module test_rarms_regs;
   logic ref_clk, rst, rms_restart, rms_done;
   logic [7:0] reg_rdata, q, d, m [256];
   logic [15:0] rms_engine_value;
   rarms_pkg::rarms_req_t reg_req;
   rarms_pkg::rarms_conv_t conv;
   rarms_pkg::rarms_cfg_t rms_setup;
   int failures, cmp_count, n, s;
   rarms_regs rarms_regs_inst (.ref_clk(ref_clk), .rst(rst),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .conv(conv),
      .rms_engine_value(rms_engine_value), .rms_setup(rms_setup),
      .rms_restart(rms_restart), .rms_done(rms_done));
   rarms_host rarms_host_inst (.ref_clk(ref_clk), .reg_req(reg_req),
      .reg_rdata(reg_rdata));
   task automatic chk(string nm, logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic rdchk(logic [7:0] a);
      rarms_host_inst.xfer(0, a, 8'h00, q);
      chk($sformatf("reg %h", a), m[a], q);
   endtask
   task automatic cv(logic [2:0] c);
      @(negedge ref_clk);
      conv = {1'b1, c, 12'($urandom)};
      // Channels 0-4 live elsewhere
      if (c > 4)
         {m[8'ha1 + 2 * c], m[8'ha0 + 2 * c]} = {conv.data, 4'h0};
   endtask
   task end_of_test;
      $display("failures %0d compares %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      ref_clk = 0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      #4800000;
      failures++;
      end_of_test();
   end
   initial
   begin
      rst = 1;
      conv = '0;
      rms_engine_value = '0;
      foreach (m[i]) m[i] = 8'h00;
      s = $urandom(36);
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 0;
      for (int a = 8'ha8; a < 8'hc4; a++) rdchk(8'(a));
      repeat (40) cv(3'($urandom));
      cv(5);
      rdchk(8'hab);
      cv(7);
      rdchk(8'hae);
      @(negedge ref_clk);
      conv = '0;
      for (int a = 8'haa; a < 8'hb0; a++) rdchk(8'(a));
      for (int i = 0; i < 8; i++)
      begin
         d = {6'($urandom), 2'(i)} | 8'h08;
         rarms_host_inst.xfer(1, 8'hc0, d, q);
         m[8'hc0] = d & 8'hf7;
         chk("rms_setup", {m[8'hc0][7:4], m[8'hc0][2:0]}, rms_setup);
         rdchk(8'hc0);
      end
      rarms_host_inst.xfer(1, 8'haa, 8'hff, q);
      rarms_host_inst.xfer(1, 8'hc1, 8'hff, q);
      rdchk(8'haa);
      rdchk(8'hc1);
      for (int w = 0; w < 4; w++)
      begin
         @(negedge ref_clk);
         conv = '0;
         m[8'hc0] = {4'h3, 1'b0, 1'(w), 2'(w)};
         rarms_host_inst.xfer(1, 8'hc0, m[8'hc0], q);
         n = 0;
         do
         begin
            cv(3);
            rms_engine_value = 16'($urandom);
            n++;
            #1;
         end
         while (rms_done !== 1'b1 && n < 70000);
         chk("done at", (1024 << (2 * w)) + 40, n);
         {m[8'hc2], m[8'hc1]} = rms_engine_value;
         rdchk(8'hc1);
         rdchk(8'hc2);
      end
      // Mid-run reset must clear results, setup and RMS value
      @(negedge ref_clk);
      conv = '0;
      rst = 1;
      foreach (m[i]) m[i] = 8'h00;
      repeat (2) @(negedge ref_clk);
      rst = 0;
      for (int a = 8'haa; a < 8'hc3; a++) rdchk(8'(a));
      chk("cfg after reset", 32'h0, rms_setup);
      end_of_test();
   end
endmodule
